// >>> shared/otp_sec_defines.svh
// Purpose: offsets, field positions, reset values and counts of the otp security block
// Assumes: apb byte addresses, 32-bit data, one word per register
// Notes: included by bare name
`ifndef OTP_SEC_DEFINES_SVH
`define OTP_SEC_DEFINES_SVH

// store geometry
`define OTP_SECTORS 4
`define OTP_ROWS_PER_SECTOR 512
`define OTP_ROWS 2048
`define OTP_AW 11
`define OTP_SEC_ROW 11'h7ff
`define OTP_LAST_COPY_ROW 11'h7fe

// apb register byte offsets
`define REG_SEC_WORD 8'h00
`define REG_PROG_ADDR 8'h04
`define REG_PROG_DATA 8'h08
`define REG_PROG_CTRL 8'h0c
`define REG_STATUS 8'h10
`define REG_READ_DATA 8'h14
`define REG_IDCODE 8'h18
`define REG_USERCODE 8'h1c

// programming control fields
`define CTRL_PROGRAM 0
`define CTRL_READ 1

// status fields
`define STAT_BUSY 0
`define STAT_BOOT_DONE 1
`define STAT_REJECTED 2
`define STAT_READ_DONE 3

// security word fields
`define SEC_NO_TAP 0
`define SEC_NO_LINK 1
`define SEC_OTP_BOOT 5
`define SEC_REDUNDANT 7
`define SEC_LOCK_LO 8
`define SEC_MASTER_LOCK 12
`define SEC_NO_TAP_OTP 13
`define SEC_GP_HI 21
`define SEC_GP_LO 15
`define SEC_UID_HI 31
`define SEC_UID_LO 22

// identity words, values arbitrary
`define ID_WORD 32'h1a2b_3c01
`define SILICON_REV 8'h01

// test port
`define TAP_RESET_TMS_CYCLES 3'h5
`define TAP_CHAIN_LEN 2'h2
`define IR_IDCODE 1'b0
`define IR_USERCODE 1'b1

`endif

// >>> shared/otp_sec_pkg.sv
// Purpose: types of the otp security block
// Assumes: nothing
// Notes: constants live in otp_sec_defines.svh
package otp_sec_pkg;
	// main sequencer states
	typedef enum logic [2:0] {
		st_load,
		st_load_wait,
		st_copy,
		st_copy_end,
		st_idle,
		st_prog,
		st_read,
		st_read_done
	} seq_state_t;
	typedef logic [10:0] row_t; // otp row index
	typedef logic [31:0] word_t; // otp data word
endpackage

// >>> core/otp_array.sv
// Purpose: one-time-programmable word array, 2048 rows of 32 bits
// Assumes: single port, read data registered one cycle after en
// Notes: a write can only set bits, as fuses do
`timescale 1ns/100ps
`default_nettype none
`include "otp_sec_defines.svh"
module otp_array (
	input wire logic clk, // block clock
	input wire logic en, // access strobe
	input wire logic we, // write when high, else read
	input wire otp_sec_pkg::row_t addr, // row index
	input wire otp_sec_pkg::word_t wdata, // bits to blow
	output otp_sec_pkg::word_t rdata // registered read word
);
	import otp_sec_pkg::*;

	word_t mem [0:`OTP_ROWS-1]; // fuse rows, unprogrammed reads zero

	// blank store at power-up
	initial begin
		for (int i = 0; i < `OTP_ROWS; i++) begin
			mem[i] = 32'h0000_0000;
		end
	end

	// fuse write ors in, read lands in output register
	always_ff @(posedge clk) begin
		if (en && we) begin
			mem[addr] <= mem[addr] | wdata;
		end
		if (en && !we) begin
			rdata <= mem[addr];
		end
	end
endmodule
`default_nettype wire

// >>> core/otp_sec_core.sv
// Purpose: otp store with security word, programming ports, boot copy and test port id words
// Assumes: apb slave on pclk, all pins but presetn synchronous to pclk, tck sampled as a level
// Notes: security word is fixed from power-up load until the next reset
`timescale 1ns/100ps
`default_nettype none
`include "otp_sec_defines.svh"
module otp_sec_core (
	input wire logic pclk, // 100 MHz clock
	input wire logic presetn, // async reset, active low
	input wire logic [7:0] paddr, // apb byte address
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb write
	input wire logic [31:0] pwdata, // apb write data
	output logic pready, // apb ready
	output logic [31:0] prdata, // apb read data
	output logic pslverr, // apb error on unmapped address
	input wire logic tck, // test clock, sampled
	input wire logic tms, // test mode select
	input wire logic jtag_ir_load, // strobe: load instruction
	input wire logic jtag_ir_code, // 0 idcode, 1 usercode
	output logic [31:0] jtag_dr_word, // word selected by instruction
	output logic tap_reset, // pulse: test port reset
	output logic [1:0] tap_count, // taps in chain
	input wire logic jtag_tile_req, // test port tile access request
	output logic jtag_tile_grant, // tile access allowed
	input wire logic jtag_otp_req, // test port otp request
	input wire logic jtag_otp_write, // otp request is a program
	input wire otp_sec_pkg::row_t jtag_otp_addr, // otp row
	input wire otp_sec_pkg::word_t jtag_otp_wdata, // otp program data
	output logic jtag_otp_ack, // pulse: request done
	output logic jtag_otp_denied, // level with ack: refused
	output otp_sec_pkg::word_t jtag_otp_rdata, // otp read data
	input wire logic link_req, // switch access from another tile
	output logic link_grant, // switch access allowed
	output logic boot_done, // load and copy finished
	output logic boot_from_otp, // start at otp address zero
	output logic redundant_en, // redundant rows in use
	output logic sram_we, // pulse: sram write
	output otp_sec_pkg::row_t sram_addr, // sram word address
	output otp_sec_pkg::word_t sram_wdata // sram write data
);
	import otp_sec_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// decode helpers

	// any lock covering this row
	function automatic logic prog_locked(input logic [3:0] lk, input logic mlk, input logic [15:0] a);
		if (mlk) prog_locked = 1'b1;
		else if (a[15:11] != 5'h00) prog_locked = 1'b1;
		else if (a[10:0] == `OTP_SEC_ROW) prog_locked = 1'b0;
		else prog_locked = lk[a[10:9]];
	endfunction

	// apb address maps to a register
	function automatic logic reg_hit(input logic [7:0] a);
		reg_hit = (a[1:0] == 2'h0) && (a <= `REG_USERCODE);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// state

	seq_state_t st_r, st_nxt; // sequencer
	word_t sec_r, sec_nxt; // security word
	logic sec_valid_r, sec_valid_nxt; // security word loaded
	row_t cnt_r, cnt_nxt; // copy row counter
	logic cp_pend_r, cp_pend_nxt; // read in flight for copy
	row_t cp_addr_r, cp_addr_nxt; // row of that read
	logic [15:0] pa_r, pa_nxt; // programming address port
	word_t pd_r, pd_nxt; // programming data port
	logic [15:0] pc_r, pc_nxt; // programming control port
	logic rej_r, rej_nxt; // last control port request refused
	logic rdone_r, rdone_nxt; // read data ready
	word_t rd_r, rd_nxt; // read result for software
	row_t op_addr_r, op_addr_nxt; // row of active operation
	word_t op_data_r, op_data_nxt; // data of active operation
	logic op_jtag_r, op_jtag_nxt; // active operation from test port
	logic pready_nxt, pslverr_nxt; // apb answer
	logic [31:0] prdata_nxt; // apb read value
	logic jack_nxt, jden_nxt; // test port otp answer
	word_t jrd_nxt; // test port otp read data
	logic tgr_nxt, lgr_nxt; // access grants
	logic bdone_nxt, sram_we_nxt; // boot outputs
	row_t sram_addr_nxt; // sram address
	word_t sram_wdata_nxt; // sram data
	logic mem_en, mem_we; // array strobes
	row_t mem_addr; // array row
	word_t mem_wdata, mem_rdata; // array data
	logic apb_wr, apb_rd; // apb write completes, apb setup phase of any transfer
	logic [3:0] sec_lock; // per-sector lock view
	logic [31:0] status_w, usercode_w; // composed read words

	////////////////////////////////////////////////////////////////////////////
	// fuse array

	otp_array u_array (
		.clk(pclk),
		.en(mem_en),
		.we(mem_we),
		.addr(mem_addr),
		.wdata(mem_wdata),
		.rdata(mem_rdata)
	);

	// per-sector lock bits
	generate
		for (genvar s = 0; s < `OTP_SECTORS; s++) begin : g_lock
			assign sec_lock[s] = sec_r[`SEC_LOCK_LO+s];
		end
	endgenerate

	// status and usercode words
	assign status_w = {28'h0000000, rdone_r, rej_r, boot_done, (st_r != st_idle)};
	assign usercode_w = {sec_r[`SEC_UID_HI:`SEC_UID_LO], 14'h0000, `SILICON_REV};
	assign apb_wr = psel && penable && pready && pwrite;
	assign apb_rd = psel && !penable;

	////////////////////////////////////////////////////////////////////////////
	// next values of sequencer, ports and bus

	always_comb begin
		st_nxt = st_r;
		sec_nxt = sec_r;
		sec_valid_nxt = sec_valid_r;
		cnt_nxt = cnt_r;
		cp_pend_nxt = 1'b0;
		cp_addr_nxt = cp_addr_r;
		pa_nxt = pa_r;
		pd_nxt = pd_r;
		pc_nxt = pc_r;
		rej_nxt = rej_r;
		rdone_nxt = rdone_r;
		rd_nxt = rd_r;
		op_addr_nxt = op_addr_r;
		op_data_nxt = op_data_r;
		op_jtag_nxt = op_jtag_r;
		jack_nxt = 1'b0;
		jden_nxt = 1'b0;
		jrd_nxt = jtag_otp_rdata;
		bdone_nxt = boot_done;
		sram_we_nxt = 1'b0;
		sram_addr_nxt = sram_addr;
		sram_wdata_nxt = sram_wdata;
		mem_en = 1'b0;
		mem_we = 1'b0;
		mem_addr = op_addr_r;
		mem_wdata = op_data_r;
		// grants follow the loaded word only
		tgr_nxt = jtag_tile_req && sec_valid_r && !sec_r[`SEC_NO_TAP];
		lgr_nxt = link_req && sec_valid_r && !sec_r[`SEC_NO_LINK];
		// apb answer one cycle into access phase
		pready_nxt = psel && penable && !pready;
		pslverr_nxt = psel && penable && !pready && !reg_hit(paddr);
		prdata_nxt = 32'h0000_0000;
		if (apb_rd) begin
			case (paddr)
				`REG_SEC_WORD: prdata_nxt = sec_r;
				`REG_PROG_ADDR: prdata_nxt = {16'h0000, pa_r};
				`REG_PROG_DATA: prdata_nxt = pd_r;
				`REG_PROG_CTRL: prdata_nxt = {16'h0000, pc_r};
				`REG_STATUS: prdata_nxt = status_w;
				`REG_READ_DATA: prdata_nxt = rd_r;
				`REG_IDCODE: prdata_nxt = `ID_WORD;
				`REG_USERCODE: prdata_nxt = usercode_w;
				default: prdata_nxt = 32'h0000_0000;
			endcase
		end else if (psel && penable && !pready) begin
			prdata_nxt = prdata;
		end
		// port writes take effect at the completing edge
		if (apb_wr && paddr == `REG_PROG_ADDR) pa_nxt = pwdata[15:0];
		if (apb_wr && paddr == `REG_PROG_DATA) pd_nxt = pwdata;
		if (apb_wr && paddr == `REG_PROG_CTRL) pc_nxt = pwdata[15:0];
		// sram write trails each copy read by a cycle
		if (cp_pend_r) begin
			sram_we_nxt = 1'b1;
			sram_addr_nxt = cp_addr_r;
			sram_wdata_nxt = mem_rdata;
		end
		case (st_r)
			st_load: begin
				// fetch the security row before anything else
				mem_en = 1'b1;
				mem_addr = `OTP_SEC_ROW;
				st_nxt = st_load_wait;
			end
			st_load_wait: begin
				sec_nxt = mem_rdata;
				sec_valid_nxt = 1'b1;
				cnt_nxt = 11'h000;
				st_nxt = st_copy;
			end
			st_copy: begin
				// stream rows below the security row
				mem_en = 1'b1;
				mem_addr = cnt_r;
				cp_pend_nxt = 1'b1;
				cp_addr_nxt = cnt_r;
				cnt_nxt = cnt_r + 11'h001;
				if (cnt_r == `OTP_LAST_COPY_ROW) st_nxt = st_copy_end;
			end
			st_copy_end: begin
				// done only once the last sram write has gone out, so no write trails it
				if (!cp_pend_r) begin
					bdone_nxt = 1'b1;
					st_nxt = st_idle;
				end
			end
			st_idle: begin
				if (apb_wr && paddr == `REG_PROG_CTRL && (pwdata[`CTRL_PROGRAM] || pwdata[`CTRL_READ])) begin
					// software command through the control port
					op_jtag_nxt = 1'b0;
					op_addr_nxt = pa_r[10:0];
					op_data_nxt = pd_r;
					rdone_nxt = 1'b0;
					rej_nxt = 1'b0;
					if (pwdata[`CTRL_PROGRAM]) begin
						if (prog_locked(sec_lock, sec_r[`SEC_MASTER_LOCK], pa_r)) rej_nxt = 1'b1;
						else st_nxt = st_prog;
					end else if (pa_r[15:11] != 5'h00) begin
						rej_nxt = 1'b1;
					end else begin
						st_nxt = st_read;
					end
				end else if (jtag_otp_req) begin
					op_jtag_nxt = 1'b1;
					op_addr_nxt = jtag_otp_addr;
					op_data_nxt = jtag_otp_wdata;
					if (sec_r[`SEC_NO_TAP_OTP] || sec_r[`SEC_NO_TAP]) begin
						jack_nxt = 1'b1;
						jden_nxt = 1'b1;
					end else if (jtag_otp_write &&
						prog_locked(sec_lock, sec_r[`SEC_MASTER_LOCK], {5'h00, jtag_otp_addr})) begin
						jack_nxt = 1'b1;
						jden_nxt = 1'b1;
					end else begin
						st_nxt = jtag_otp_write ? st_prog : st_read;
					end
				end
			end
			st_prog: begin
				// lock already checked at acceptance
				mem_en = 1'b1;
				mem_we = 1'b1;
				jack_nxt = op_jtag_r;
				st_nxt = st_idle;
			end
			st_read: begin
				mem_en = 1'b1;
				st_nxt = st_read_done;
			end
			st_read_done: begin
				if (op_jtag_r) begin
					jack_nxt = 1'b1;
					jrd_nxt = mem_rdata;
				end else begin
					rd_nxt = mem_rdata;
					rdone_nxt = 1'b1;
				end
				st_nxt = st_idle;
			end
			default: st_nxt = st_load;
		endcase
	end

	// register the sequencer group
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= st_load;
			sec_r <= 32'h0000_0000;
			sec_valid_r <= 1'b0;
			cnt_r <= 11'h000;
			cp_pend_r <= 1'b0;
			cp_addr_r <= 11'h000;
			pa_r <= 16'h0000;
			pd_r <= 32'h0000_0000;
			pc_r <= 16'h0000;
			rej_r <= 1'b0;
			rdone_r <= 1'b0;
			rd_r <= 32'h0000_0000;
			op_addr_r <= 11'h000;
			op_data_r <= 32'h0000_0000;
			op_jtag_r <= 1'b0;
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
			jtag_otp_ack <= 1'b0;
			jtag_otp_denied <= 1'b0;
			jtag_otp_rdata <= 32'h0000_0000;
			jtag_tile_grant <= 1'b0;
			link_grant <= 1'b0;
			boot_done <= 1'b0;
			boot_from_otp <= 1'b0;
			redundant_en <= 1'b0;
			sram_we <= 1'b0;
			sram_addr <= 11'h000;
			sram_wdata <= 32'h0000_0000;
		end else begin
			st_r <= st_nxt;
			sec_r <= sec_nxt;
			sec_valid_r <= sec_valid_nxt;
			cnt_r <= cnt_nxt;
			cp_pend_r <= cp_pend_nxt;
			cp_addr_r <= cp_addr_nxt;
			pa_r <= pa_nxt;
			pd_r <= pd_nxt;
			pc_r <= pc_nxt;
			rej_r <= rej_nxt;
			rdone_r <= rdone_nxt;
			rd_r <= rd_nxt;
			op_addr_r <= op_addr_nxt;
			op_data_r <= op_data_nxt;
			op_jtag_r <= op_jtag_nxt;
			pready <= pready_nxt;
			pslverr <= pslverr_nxt;
			prdata <= prdata_nxt;
			jtag_otp_ack <= jack_nxt;
			jtag_otp_denied <= jden_nxt;
			jtag_otp_rdata <= jrd_nxt;
			jtag_tile_grant <= tgr_nxt;
			link_grant <= lgr_nxt;
			boot_done <= bdone_nxt;
			boot_from_otp <= sec_valid_nxt && sec_nxt[`SEC_OTP_BOOT];
			redundant_en <= sec_valid_nxt && sec_nxt[`SEC_REDUNDANT];
			sram_we <= sram_we_nxt;
			sram_addr <= sram_addr_nxt;
			sram_wdata <= sram_wdata_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// test port reset and instruction

	logic tck_d_r, tck_d_nxt; // tck of last cycle
	logic [2:0] tms_cnt_r, tms_cnt_nxt; // consecutive tms-high clocks
	logic ir_r, ir_nxt; // current instruction
	logic tap_rst_nxt; // reset pulse
	logic [31:0] dr_nxt; // selected word

	// count tms high on tck rising edges
	always_comb begin
		tck_d_nxt = tck;
		tms_cnt_nxt = tms_cnt_r;
		ir_nxt = ir_r;
		tap_rst_nxt = 1'b0;
		if (tck && !tck_d_r) begin
			if (!tms) begin
				tms_cnt_nxt = 3'h0;
			end else if (tms_cnt_r == `TAP_RESET_TMS_CYCLES - 3'h1) begin
				tms_cnt_nxt = `TAP_RESET_TMS_CYCLES;
				tap_rst_nxt = 1'b1;
				ir_nxt = `IR_IDCODE;
			end else if (tms_cnt_r != `TAP_RESET_TMS_CYCLES) begin
				tms_cnt_nxt = tms_cnt_r + 3'h1;
			end
		end
		if (jtag_ir_load && !tap_rst_nxt) ir_nxt = jtag_ir_code;
		dr_nxt = (ir_nxt == `IR_USERCODE) ? usercode_w : `ID_WORD;
	end

	// register the test port group
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tck_d_r <= 1'b0;
			tms_cnt_r <= 3'h0;
			ir_r <= `IR_IDCODE;
			tap_reset <= 1'b0;
			tap_count <= `TAP_CHAIN_LEN;
			jtag_dr_word <= `ID_WORD;
		end else begin
			tck_d_r <= tck_d_nxt;
			tms_cnt_r <= tms_cnt_nxt;
			ir_r <= ir_nxt;
			tap_reset <= tap_rst_nxt;
			tap_count <= `TAP_CHAIN_LEN;
			jtag_dr_word <= dr_nxt;
		end
	end
endmodule
`default_nettype wire

// >>> tb/otp_sec_checker_sva.sv
// Purpose: port checker for the otp security block
// Assumes: one pclk domain, async active-low reset
// Notes: bound to otp_sec_core after the module
`timescale 1ns/100ps
`default_nettype none
`include "otp_sec_defines.svh"
module otp_sec_checker (
	input wire logic pclk, // block clock
	input wire logic presetn, // async reset, active low
	input wire logic [7:0] paddr, // apb address
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pready, // apb ready
	input wire logic pslverr, // apb error
	input wire logic tms, // test mode select
	input wire logic tap_reset, // test port reset pulse
	input wire logic [1:0] tap_count, // taps in chain
	input wire logic [31:0] jtag_dr_word, // word selected by instruction
	input wire logic link_req, // switch request
	input wire logic link_grant, // switch grant
	input wire logic jtag_tile_req, // tile request
	input wire logic jtag_tile_grant, // tile grant
	input wire logic jtag_otp_ack, // otp request done
	input wire logic jtag_otp_denied, // otp request refused
	input wire logic boot_done, // boot finished
	input wire logic sram_we, // sram write pulse
	input wire otp_sec_pkg::row_t sram_addr // sram address
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	////////////////////////////////////////////////////////////
	a_chain_taps: assert property (tap_count == `TAP_CHAIN_LEN)
		else $error("tap count wrong");
	a_tap_reset_tms: assert property (tap_reset |-> $past(tms) ##1 !tap_reset)
		else $error("test port reset without tms high");
	a_tap_reset_id: assert property (tap_reset |-> ##[1:2] jtag_dr_word == `ID_WORD)
		else $error("idcode not selected after test port reset");
	a_link_needs_req: assert property (link_grant |-> $past(link_req))
		else $error("switch grant without request");
	a_tile_needs_req: assert property (jtag_tile_grant |-> $past(jtag_tile_req))
		else $error("tile grant without request");
	a_denied_with_ack: assert property (jtag_otp_denied |-> jtag_otp_ack)
		else $error("refusal without ack");
	a_boot_done_holds: assert property (boot_done |=> boot_done)
		else $error("boot done dropped");
	a_copy_before_done: assert property (sram_we |-> !boot_done && sram_addr != `OTP_SEC_ROW)
		else $error("copy after boot or of security row");
	a_ready_one_wait: assert property (psel && !penable |-> ##2 pready)
		else $error("apb answer not after one wait state");
	a_unmapped_err: assert property (psel && penable && pready && paddr > 8'h1c |-> pslverr)
		else $error("unmapped access without error");
endmodule
bind otp_sec_core otp_sec_checker chk_u (.pclk, .presetn, .paddr, .psel, .penable, .pready, .pslverr, .tms,
	.tap_reset, .tap_count, .jtag_dr_word, .link_req, .link_grant, .jtag_tile_req, .jtag_tile_grant,
	.jtag_otp_ack, .jtag_otp_denied, .boot_done, .sram_we, .sram_addr);
`default_nettype wire

// >>> tb/otp_jtag_host.sv
// Purpose: test port host model driving tck, tms and otp requests
// Assumes: tck toggled on pclk edges, stands low between uses
// Notes: tasks are called from the bench
`timescale 1ns/100ps
`default_nettype none
module otp_jtag_host (
	input wire logic pclk, // block clock
	output logic tck, // test clock
	output logic tms, // test mode select
	output logic jtag_ir_load, // instruction load strobe
	output logic jtag_ir_code, // instruction code
	output logic jtag_otp_req, // otp request pulse
	output logic jtag_otp_write, // request is a program
	output otp_sec_pkg::row_t jtag_otp_addr, // otp row
	output otp_sec_pkg::word_t jtag_otp_wdata, // program data
	input wire logic jtag_otp_ack, // request done
	input wire logic jtag_otp_denied, // request refused
	input wire otp_sec_pkg::word_t jtag_otp_rdata // read data
);
	import otp_sec_pkg::*;
	logic den = 1'b0; // refusal seen on last request
	initial begin
		tck = 1'b0;
		tms = 1'b0;
		jtag_ir_load = 1'b0;
		jtag_ir_code = 1'b0;
		jtag_otp_req = 1'b0;
		jtag_otp_write = 1'b0;
		jtag_otp_addr = 11'h000;
		jtag_otp_wdata = 32'h5a5a_a5a5;
	end
	////////////////////////////////////////////////////////////
	// n test clocks with tms held at v
	task tms_run(input int n, input logic v);
		repeat (n) begin
			tms <= v;
			@(posedge pclk) tck <= 1'b1;
			@(posedge pclk) tck <= 1'b0;
		end
	endtask
	// load an instruction with a one-cycle strobe
	task load_ir(input logic c);
		jtag_ir_code <= c;
		jtag_ir_load <= 1'b1;
		@(posedge pclk) jtag_ir_load <= 1'b0;
	endtask
	// one otp read, waits for ack under a bound
	task otp_rd(input row_t a);
		int n;
		n = 0;
		jtag_otp_req <= 1'b1;
		jtag_otp_addr <= a;
		@(posedge pclk);
		jtag_otp_req <= 1'b0;
		jtag_otp_addr <= ~a; // address no longer valid once taken
		while (jtag_otp_ack !== 1'b1 && n < 10) begin
			@(posedge pclk);
			n++;
		end
		den = jtag_otp_denied;
		@(posedge pclk);
	endtask
	// one otp program: write flag and data stand with the request
	task otp_wr(input row_t a, input word_t d);
		jtag_otp_write <= 1'b1;
		jtag_otp_wdata <= d;
		otp_rd(a);
		jtag_otp_write <= 1'b0;
	endtask
endmodule
`default_nettype wire

// >>> tb/otp_security_config_bench.sv
// Purpose: self-checking bench for the otp security block
// Assumes: apb master tasks, host model on the test port
// Notes: otp contents survive reset, so later boots load the programmed word
`timescale 1ns/100ps
`default_nettype none
`include "otp_sec_defines.svh"
module otp_security_config_bench;
	import otp_sec_pkg::*;
	localparam word_t SEC1 = 32'h8040_a1a3; // tap, link, boot, redundant, lock 0, tap otp, gp, uid
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic link_req = 1'b0, jtag_tile_req = 1'b0, err;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd, st, jtag_dr_word;
	logic pready, pslverr, tck, tms, jtag_ir_load, jtag_ir_code, tap_reset, jtag_tile_grant, jtag_otp_req;
	logic jtag_otp_write, jtag_otp_ack, jtag_otp_denied, link_grant, boot_done, boot_from_otp;
	logic redundant_en, sram_we;
	logic [1:0] tap_count;
	row_t jtag_otp_addr, sram_addr;
	word_t jtag_otp_wdata, jtag_otp_rdata, sram_wdata;
	word_t row5 = 32'h0; // word copied to sram for row 5
	int error_cnt = 0, checked = 0, copies = 0, taps = 0;
	always #5 pclk = ~pclk;
	otp_sec_core dut_u (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pready, .prdata, .pslverr,
		.tck, .tms, .jtag_ir_load, .jtag_ir_code, .jtag_dr_word, .tap_reset, .tap_count, .jtag_tile_req,
		.jtag_tile_grant, .jtag_otp_req, .jtag_otp_write, .jtag_otp_addr, .jtag_otp_wdata, .jtag_otp_ack,
		.jtag_otp_denied, .jtag_otp_rdata, .link_req, .link_grant, .boot_done, .boot_from_otp, .redundant_en,
		.sram_we, .sram_addr, .sram_wdata);
	otp_jtag_host host_u (.pclk, .tck, .tms, .jtag_ir_load, .jtag_ir_code, .jtag_otp_req, .jtag_otp_write,
		.jtag_otp_addr, .jtag_otp_wdata, .jtag_otp_ack, .jtag_otp_denied, .jtag_otp_rdata);
	// count copied words and test port resets
	always @(posedge pclk) begin
		if (!presetn) copies <= 0;
		else if (sram_we === 1'b1) copies <= copies + 1;
		if (tap_reset === 1'b1) taps <= taps + 1;
		if (sram_we === 1'b1 && sram_addr === 11'h005) row5 <= sram_wdata;
	end
	////////////////////////////////////////////////////////////
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one apb transfer; result in rd and err
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk) penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) error_cnt++;
		@(posedge pclk);
	endtask
	task rdchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask
	// programming command, status afterwards in st
	task op(input logic [15:0] c, input logic [31:0] a, input logic [31:0] d);
		apb(1'b1, `REG_PROG_ADDR, a);
		apb(1'b1, `REG_PROG_DATA, d);
		apb(1'b1, `REG_PROG_CTRL, {16'h0, c});
		repeat (3) @(posedge pclk);
		apb(1'b0, `REG_STATUS, 32'h0);
		st = rd;
	endtask
	// reset for two cycles, then wait for load and copy
	task boot;
		int n;
		n = 0;
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		while (boot_done !== 1'b1 && n < 3000) begin
			@(posedge pclk);
			n++;
		end
		chk(boot_done, 1);
		chk(copies, 2047);
	endtask
	task end_sim;
		$display("checks %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		#200000;
		error_cnt++;
		end_sim();
	end
	////////////////////////////////////////////////////////////
	initial begin
		@(posedge pclk);
		boot();
		rdchk(`REG_SEC_WORD, 32'h0);
		rdchk(`REG_IDCODE, `ID_WORD);
		rdchk(`REG_USERCODE, {24'h0, `SILICON_REV});
		apb(1'b1, `REG_SEC_WORD, 32'hffff_ffff);
		rdchk(`REG_SEC_WORD, 32'h0);
		apb(1'b0, 8'h20, 32'h0);
		chk(err, 1);
		chk(tap_count, 2);
		$display("test blank_boot done");
		op(16'h1, 32'h5, 32'ha5);
		chk(st[2], 0);
		op(16'h2, 32'h5, 32'h0);
		chk(st[3:2], 2'h2);
		rdchk(`REG_READ_DATA, 32'ha5);
		op(16'h1, 32'h800, 32'h1);
		chk(st[2], 1);
		host_u.otp_rd(11'h005);
		chk(host_u.den, 0);
		chk(jtag_otp_rdata, 32'ha5);
		host_u.otp_wr(11'h006, 32'h3c);
		chk(host_u.den, 0);
		host_u.otp_rd(11'h006);
		chk(jtag_otp_rdata, 32'h3c);
		link_req <= 1'b1;
		jtag_tile_req <= 1'b1;
		repeat (3) @(posedge pclk);
		chk(link_grant, 1);
		chk(jtag_tile_grant, 1);
		$display("test program_read done");
		host_u.load_ir(1'b1);
		repeat (2) @(posedge pclk);
		chk(jtag_dr_word, {24'h0, `SILICON_REV});
		host_u.tms_run(4, 1'b1);
		host_u.tms_run(1, 1'b0);
		chk(taps, 0);
		host_u.tms_run(5, 1'b1);
		repeat (3) @(posedge pclk);
		chk(taps, 1);
		chk(jtag_dr_word, `ID_WORD);
		$display("test test_port done");
		op(16'h1, 32'h7ff, SEC1);
		boot();
		rdchk(`REG_SEC_WORD, SEC1);
		rdchk(`REG_USERCODE, {SEC1[31:22], 14'h0, `SILICON_REV});
		chk(boot_from_otp, 1);
		chk(redundant_en, 1);
		chk(row5, 32'ha5);
		chk(link_grant, 0);
		chk(jtag_tile_grant, 0);
		host_u.otp_rd(11'h005);
		chk(host_u.den, 1);
		host_u.otp_wr(11'h006, 32'h1);
		chk(host_u.den, 1);
		op(16'h1, 32'h3, 32'hf);
		chk(st[2], 1);
		op(16'h2, 32'h3, 32'h0);
		rdchk(`REG_READ_DATA, 32'h0);
		op(16'h1, 32'h200, 32'h1);
		chk(st[2], 0);
		$display("test secured_boot done");
		op(16'h1, 32'h7ff, 32'h1000);
		boot();
		op(16'h1, 32'h7ff, 32'h4);
		chk(st[2], 1);
		op(16'h1, 32'h600, 32'h4);
		chk(st[2], 1);
		rdchk(`REG_SEC_WORD, SEC1 | 32'h1000);
		$display("test master_lock done");
		end_sim();
	end
endmodule
`default_nettype wire
